// file: design/crtp_top.v
/*
 * Request-to-send pin control and transmit identifier registers of a
 * CAN controller, reached over a mode 0,0 serial register port.
 * Assumes serial pins synchronous to clk_in (request pins are synchronised here), serial clock
 * at most a quarter of clk_in, and the protocol engine outside.
 */
`timescale 1ns/100ps
`include "crtp_map.vh"

module crtp_top (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // serial register port
  input  wire        spi_cs_n_in,
  input  wire        spi_sck_in,
  input  wire        spi_si_in,
  output wire        spi_so_out,
  output wire        spi_so_oe_n_out,
  // request pins, active low
  input  wire [2:0]  send_request_pin_n_in,
  // device mode
  input  wire        config_mode_in,
  // to the transmit engine
  output reg  [2:0]  transmit_request_out,
  output wire [2:0]  extended_enable_out,
  output wire [32:0] standard_identifier_out,
  output wire [5:0]  extended_identifier_out
);

  // request pin path
  reg  [2:0]  pin_meta;
  reg  [2:0]  pin_sync;
  reg  [2:0]  pin_prev;
  reg  [2:0]  pin_mode;
  wire [2:0]  pin_level;
  wire [2:0]  pin_fall;

  // serial engine
  reg         sck_prev;
  reg  [2:0]  bit_cnt;
  reg  [1:0]  phase;
  reg  [7:0]  cmd;
  reg  [7:0]  addr;
  reg  [7:0]  rx_shift;
  reg  [7:0]  tx_shift;
  wire        sck_rise;
  wire        sck_fall;
  wire        byte_done;
  wire [7:0]  rx_byte;
  wire        wr_data;

  // address decode
  wire        hit_ctrl;
  wire        hit_id;
  wire [1:0]  id_buf;
  wire [2:0]  id_idx;
  wire [7:0]  ctrl_byte;
  wire [7:0]  id_rd_data;
  wire [47:0] id_flat;
  reg  [7:0]  rd_byte;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_prev <= 3'h7;
    end else begin
      pin_meta <= send_request_pin_n_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_fall = pin_prev & ~pin_sync & pin_mode;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      transmit_request_out <= 3'h0;
    end else begin
      transmit_request_out <= pin_fall;
    end
  end

  assign pin_level = pin_sync & ~pin_mode;

  assign ctrl_byte = {2'h0, pin_level, pin_mode};

  // serial edges; sck is already synchronous here
  assign sck_rise  = ~spi_cs_n_in & spi_sck_in & ~sck_prev;
  assign sck_fall  = ~spi_cs_n_in & ~spi_sck_in & sck_prev;
  assign byte_done = sck_rise && bit_cnt == 3'h7;
  assign rx_byte   = {rx_shift[6:0], spi_si_in};
  assign wr_data   = byte_done && phase == `CRTP_PH_DATA &&
                     cmd == `CRTP_CMD_WRITE;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sck_prev <= 1'b0;
      bit_cnt  <= 3'h0;
      phase    <= `CRTP_PH_CMD;
      cmd      <= 8'h00;
      addr     <= 8'h00;
      rx_shift <= 8'h00;
    end else begin
      sck_prev <= spi_sck_in;
      if (spi_cs_n_in) begin
        // frame ends: next byte is a command again
        bit_cnt <= 3'h0;
        phase   <= `CRTP_PH_CMD;
      end else if (sck_rise) begin
        bit_cnt  <= bit_cnt + 3'h1;
        rx_shift <= rx_byte;
        if (byte_done) begin
          case (phase)
            `CRTP_PH_CMD: begin
              cmd   <= rx_byte;
              phase <= `CRTP_PH_ADDR;
            end
            `CRTP_PH_ADDR: begin
              addr  <= rx_byte;
              phase <= `CRTP_PH_DATA;
            end
            `CRTP_PH_DATA: begin
              // sequential access walks up the map
              addr <= addr + 8'h01;
            end
            default: begin
              phase <= `CRTP_PH_CMD;
            end
          endcase
        end
      end
    end
  end

  // decode of the pin control register and the identifier block
  assign id_buf   = addr[5:4] - 2'h3;
  assign hit_ctrl = addr == `CRTP_ADDR_PIN_CTRL;
  assign hit_id   = (addr[7:4] == `CRTP_ID_BASE_NIB ||
                     addr[7:4] == `CRTP_ID_BASE_NIB + 4'h1 ||
                     addr[7:4] == `CRTP_ID_BASE_NIB + 4'h2) &&
                    (addr[3:0] == `CRTP_ID_HI_NIB ||
                     addr[3:0] == `CRTP_ID_LO_NIB);
  assign id_idx   = {id_buf, addr[3:0] == `CRTP_ID_LO_NIB};

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_mode <= `CRTP_MODE_RESET;
    end else if (wr_data && hit_ctrl && config_mode_in) begin
      // level and top bits not writable
      pin_mode <= rx_byte[`CRTP_MODE_MSB:`CRTP_MODE_LSB];
    end
  end

  crtp_id_store u_id_store (
    .clk_in      (clk_in),
    .wr_en_in    (wr_data && hit_id),
    .wr_idx_in   (id_idx),
    .wr_data_in  (rx_byte),
    .rd_idx_in   (id_idx),
    .rd_data_out (id_rd_data),
    .id_flat_out (id_flat)
  );

  // unmapped addresses read zero
  always @* begin
    if (hit_ctrl) begin
      rd_byte = ctrl_byte;
    end else if (hit_id) begin
      rd_byte = id_rd_data;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // read data loaded on the falling edge that opens each data byte;
  // store latency is hidden by the slow serial clock
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_shift <= 8'h00;
    end else if (spi_cs_n_in) begin
      tx_shift <= 8'h00;
    end else if (sck_fall) begin
      if (bit_cnt == 3'h0 && phase == `CRTP_PH_DATA &&
          cmd == `CRTP_CMD_READ) begin
        tx_shift <= rd_byte;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  assign spi_so_out      = tx_shift[7];
  assign spi_so_oe_n_out = spi_cs_n_in;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      assign extended_enable_out[g] =
        id_flat[g*16 + 8 + `CRTP_LO_EXT_BIT];
      assign standard_identifier_out[g*11 +: 11] =
        {id_flat[g*16 +: 8], id_flat[g*16 + 8 + `CRTP_LO_STD_LSB +: 3]};
      assign extended_identifier_out[g*2 +: 2] = id_flat[g*16 + 8 +: 2];
    end
  endgenerate

endmodule // crtp_top

// file: design/crtp_map.vh
/*
 * Register map, field positions, reset values and serial command codes
 * of the request-pin and transmit-identifier block.
 * Assumes it is included by bare name from the design files.
 */
`ifndef CRTP_MAP_VH
`define CRTP_MAP_VH

// register offsets
`define CRTP_ADDR_PIN_CTRL   8'h0D
`define CRTP_ADDR_TX0_ID_HI  8'h31
`define CRTP_ADDR_TX0_ID_LO  8'h32
`define CRTP_ADDR_TX1_ID_HI  8'h41
`define CRTP_ADDR_TX1_ID_LO  8'h42
`define CRTP_ADDR_TX2_ID_HI  8'h51
`define CRTP_ADDR_TX2_ID_LO  8'h52
// identifier registers: high nibble picks the buffer
`define CRTP_ID_BASE_NIB     4'h3
`define CRTP_ID_HI_NIB       4'h1
`define CRTP_ID_LO_NIB       4'h2

// request_pin_control fields
`define CRTP_MODE_LSB        0
`define CRTP_MODE_MSB        2
`define CRTP_LEVEL_LSB       3
`define CRTP_LEVEL_MSB       5
`define CRTP_MODE_RESET      3'h0

// std_id_low fields
`define CRTP_LO_STD_LSB      5
`define CRTP_LO_EXT_BIT      3
`define CRTP_LO_WMASK        8'hEB

// serial commands
`define CRTP_CMD_WRITE       8'h02
`define CRTP_CMD_READ        8'h03

// serial phases
`define CRTP_PH_CMD          2'h0
`define CRTP_PH_ADDR         2'h1
`define CRTP_PH_DATA         2'h2

`endif

// file: design/crtp_id_store.v
/*
 * Identifier store of the three transmit buffers: a high and a low
 * identifier byte each, with a registered read port.
 * Assumes one write per cycle, index = {buffer, low_select}.
 */
`timescale 1ns/100ps
`include "crtp_map.vh"

module crtp_id_store (
  // clock
  input  wire        clk_in,
  // write port
  input  wire        wr_en_in,
  input  wire [2:0]  wr_idx_in,
  input  wire [7:0]  wr_data_in,
  // read port
  input  wire [2:0]  rd_idx_in,
  output reg  [7:0]  rd_data_out,
  // every byte, buffer 2 low byte on top
  output wire [47:0] id_flat_out
);

  reg  [7:0] id_hi [0:2];
  reg  [7:0] id_lo [0:2];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_buf
      // store index of this buffer's high and low byte
      localparam [2:0] HI_IDX = 2 * g;
      localparam [2:0] LO_IDX = 2 * g + 1;
      // no reset: identifier contents are undefined after power-up
      always @(posedge clk_in) begin
        if (wr_en_in && wr_idx_in == HI_IDX) begin
          id_hi[g] <= wr_data_in;
        end
        if (wr_en_in && wr_idx_in == LO_IDX) begin
          id_lo[g] <= wr_data_in & `CRTP_LO_WMASK;
        end
      end
      assign id_flat_out[g*16 +: 8]     = id_hi[g];
      assign id_flat_out[g*16 + 8 +: 8] = id_lo[g];
    end
  endgenerate

  always @(posedge clk_in) begin
    if (rd_idx_in[2:1] > 2'h2) begin
      rd_data_out <= 8'h00;
    end else if (rd_idx_in[0]) begin
      rd_data_out <= id_lo[rd_idx_in[2:1]];
    end else begin
      rd_data_out <= id_hi[rd_idx_in[2:1]];
    end
  end

endmodule // crtp_id_store

// file: tb/crtp_properties.sv
/* Checker on the ports of crtp_top.
   Assumes it is bound to the top from the bench. */
`timescale 1ns/100ps
module crtp_properties (
  // watched ports
  input wire        clk_in,
  input wire        reset_in,
  input wire        spi_cs_n_in,
  input wire        spi_sck_in,
  input wire        config_mode_in,
  input wire        spi_so_out,
  input wire        spi_so_oe_n_out,
  input wire [2:0]  send_request_pin_n_in,
  input wire [2:0]  transmit_request_out,
  input wire [2:0]  extended_enable_out,
  input wire [32:0] standard_identifier_out,
  input wire [5:0]  extended_identifier_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // modes leave zero only through a configuration frame
  reg armed;
  always @(posedge clk_in or posedge reset_in)
    if (reset_in)
      armed <= 1'b0;
    else if (!spi_cs_n_in && config_mode_in)
      armed <= 1'b1;
  pulse_once_a: assert property (
    (transmit_request_out & $past(transmit_request_out)) == 3'h0)
    else $error("request pulse too long");
  pulse_cause_a: assert property (
    (transmit_request_out & $past(send_request_pin_n_in, 2)) == 3'h0)
    else $error("request without low pin");
  mode_reset_a: assert property (
    transmit_request_out != 3'h0 |-> armed)
    else $error("request before any mode write");
  sync_delay_a: assert property (
    $fell(send_request_pin_n_in[0]) |->
      !transmit_request_out[0] ##1 !transmit_request_out[0])
    else $error("request before pin sync");
  ext_write_a: assert property (
    $changed(extended_enable_out) |->
      !$past(spi_cs_n_in) && $past(spi_sck_in))
    else $error("extended enable moved outside write");
  std_write_a: assert property (
    $changed(standard_identifier_out) |->
      !$past(spi_cs_n_in) && $past(spi_sck_in))
    else $error("identifier moved outside write");
  xid_write_a: assert property (
    $changed(extended_identifier_out) |->
      !$past(spi_cs_n_in) && $past(spi_sck_in))
    else $error("extended bits moved outside write");
  so_idle_a: assert property (
    spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_so_out)
    else $error("serial out busy while idle");
  so_enable_a: assert property (
    spi_so_oe_n_out == spi_cs_n_in)
    else $error("serial out enable not following select");
endmodule // crtp_properties

// file: tb/crtp_host.sv
/* Host model: mode 0,0 serial master, one data byte a frame.
   Assumes clk_in free running; sck levels of 2 and 3 clocks. */
`timescale 1ns/100ps
module crtp_host (
  // clock
  input  wire clk_in,
  // serial port
  input  wire spi_so_in,
  output reg  spi_cs_n_out,
  output reg  spi_sck_out,
  output reg  spi_si_out
);
  initial begin
    spi_cs_n_out = 1'b1;
    spi_sck_out = 1'b0;
    spi_si_out = 1'b0;
  end
  task xfer(input [7:0] cmd, input [7:0] adr, input [7:0] wd,
            output [7:0] rd);
    reg [23:0] sh;
    integer    i;
    begin
      sh = {cmd, adr, wd};
      @(posedge clk_in) spi_cs_n_out <= 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
        spi_si_out <= sh[23 - i];
        // three low clocks: read bit lands one clock after the fall
        repeat (3) @(posedge clk_in);
        rd = {rd[6:0], spi_so_in};
        spi_sck_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        spi_sck_out <= 1'b0;
      end
      repeat (2) @(posedge clk_in);
      spi_cs_n_out <= 1'b1;
      spi_si_out <= ~spi_si_out;
      @(posedge clk_in);
    end
  endtask
endmodule // crtp_host

// file: tb/can_tx_request_pins_and_identifier_tb.sv
/* Bench: id table, pin control, request pulses, resets.
   Assumes crtp_host as serial master, checker bound below. */
`timescale 1ns/100ps
`include "crtp_map.vh"
module can_tx_request_pins_and_identifier_tb;
  reg         clk_in;
  reg         reset_in;
  reg  [2:0]  pin_n;
  reg         cfg;
  wire        cs_n;
  wire        sck;
  wire        si;
  wire        so;
  wire [2:0]  txr;
  wire [2:0]  ext;
  wire [32:0] std_id;
  wire [5:0]  ext_id;
  reg  [7:0]  rd;
  reg  [2:0]  acc;
  reg  [23:0] rows [0:5];
  integer     err_count;
  integer     tests_run;
  integer     i;
  integer     n;
  crtp_host host (.clk_in(clk_in), .spi_so_in(so), .spi_cs_n_out(cs_n),
    .spi_sck_out(sck), .spi_si_out(si));
  crtp_top uut (.clk_in(clk_in), .reset_in(reset_in), .spi_cs_n_in(cs_n),
    .spi_sck_in(sck), .spi_si_in(si), .spi_so_out(so),
    .spi_so_oe_n_out(), .send_request_pin_n_in(pin_n),
    .config_mode_in(cfg), .transmit_request_out(txr),
    .extended_enable_out(ext), .standard_identifier_out(std_id),
    .extended_identifier_out(ext_id));
  task chk(input [32:0] got, input [32:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    host.xfer(`CRTP_CMD_WRITE, a, d, rd);
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      host.xfer(`CRTP_CMD_READ, a, 8'h00, rd);
      chk({25'h0, rd}, {25'h0, e});
    end
  endtask
  // drop pins in m, gather request pulses over ten clocks
  task pulses(input [2:0] m);
    begin
      acc = 3'h0;
      n = 0;
      pin_n <= pin_n & ~m;
      repeat (10) begin
        @(posedge clk_in);
        #1 acc = acc | txr;
        n = n + $countones(txr);
      end
      // back onto the edge so later stimulus lands there
      @(posedge clk_in);
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #1000000 err_count = err_count + 1;
    close_out;
  end
  initial begin
    reset_in = 1'b1;
    pin_n = 3'h7;
    cfg = 1'b0;
    err_count = 0;
    tests_run = 0;
    rows[0] = 24'h31A5A5;
    rows[1] = 24'h32FFEB;
    rows[2] = 24'h413C3C;
    rows[3] = 24'h421400;
    rows[4] = 24'h51FFFF;
    rows[5] = 24'h526B6B;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rdchk(`CRTP_ADDR_PIN_CTRL, 8'h38);
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
    end
    chk(std_id, {11'h7FB, 11'h1E0, 11'h52F});
    chk({30'h0, ext}, 33'h5);
    chk({27'h0, ext_id}, 33'h33);
    rdchk(8'h20, 8'h00);
    $display("id test done");
    wr(`CRTP_ADDR_PIN_CTRL, 8'hFF);
    rdchk(`CRTP_ADDR_PIN_CTRL, 8'h38);
    pulses(3'h7);
    chk({30'h0, acc}, 33'h0);
    pin_n <= 3'h7;
    cfg <= 1'b1;
    wr(`CRTP_ADDR_PIN_CTRL, 8'hFF);
    rdchk(`CRTP_ADDR_PIN_CTRL, 8'h07);
    pulses(3'h7);
    chk({30'h0, acc}, 33'h7);
    chk({1'b0, n}, 33'h3);
    pin_n <= 3'h7;
    wr(`CRTP_ADDR_PIN_CTRL, 8'h02);
    rdchk(`CRTP_ADDR_PIN_CTRL, 8'h2A);
    pulses(3'h7);
    chk({30'h0, acc}, 33'h2);
    $display("pin test done");
    pin_n <= 3'h7;
    @(posedge clk_in) reset_in <= 1'b1;
    @(posedge clk_in) reset_in <= 1'b0;
    rdchk(`CRTP_ADDR_PIN_CTRL, 8'h38);
    $display("second reset test done");
    close_out;
  end
endmodule // can_tx_request_pins_and_identifier_tb
bind crtp_top crtp_properties chk_i (.clk_in, .reset_in, .spi_cs_n_in,
  .spi_sck_in, .config_mode_in, .spi_so_out, .spi_so_oe_n_out,
  .send_request_pin_n_in,
  .transmit_request_out, .extended_enable_out, .standard_identifier_out,
  .extended_identifier_out);
